//--- src/bss_params.svh
// constants of the boot startup sequencer: offsets, fields, resets, timing
// assumes a 100 MHz clock and a 32-bit register port
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH

`define BSS_ADR_CAUSE       4'h0
`define BSS_ADR_CTRL        4'h4
`define BSS_ADR_STATUS      4'h8
`define BSS_ADR_RESULT      4'hC

`define BSS_CTRL_FORCE      0
`define BSS_CAUSE_WDT       2
`define BSS_CAUSE_SLEEPX    4
`define BSS_CAUSE_RST       8'h01
`define BSS_COLD_MASK       8'h0F
`define BSS_WARM_MASK       8'h30

`define BSS_CLK_MHZ         100
`define BSS_NAC_STEP_MS     5
`define BSS_NAC_MAX_MS      140
`define BSS_STEP_CYC        (`BSS_NAC_STEP_MS * 1000 * `BSS_CLK_MHZ)
`define BSS_NAC_MAX_STEPS   8'((`BSS_NAC_MAX_MS) / (`BSS_NAC_STEP_MS))
`define BSS_NAC_CLOSED      8'h00
`define BSS_NAC_FOREVER     8'hFF
`define BSS_NAD_BCAST       8'hFF
`define BSS_NAC_RST         8'hFF
`define BSS_NAD_RST         8'hFF

`define BSS_WDT_LONG_CYC    32'h000F4240
`define BSS_WDT_WIN_CYC     32'h000186A0
`define BSS_WDT_SLEEP_CNT   3'h5

`define BSS_LOW_EXCL_BYTES  1024
`define BSS_WORD_BYTES      4
`define BSS_LOW_EXCL_WORDS  ((`BSS_LOW_EXCL_BYTES) / (`BSS_WORD_BYTES))
`define BSS_PAT_EVEN        32'h55555555
`define BSS_PAT_ODD         32'hAAAAAAAA

`define BSS_CS_TRIM_BASE    8'h00
`define BSS_CS_USER0        8'h10
`define BSS_CS_NAC          8'h20
`define BSS_CS_NAD          8'h21

`endif

//--- src/bss_pkg.sv
// types of the boot startup sequencer
// state and reset type codes are set here, not taken from bss_params.svh
package bss_pkg;

  typedef enum logic [3:0] {
    BSS_CLASSIFY = 4'h0,
    BSS_WDT_SET  = 4'h1,
    BSS_TEST_WR  = 4'h3,
    BSS_TEST_RD  = 4'h2,
    BSS_INIT     = 4'h6,
    BSS_TRIM     = 4'h7,
    BSS_NAC      = 4'h5,
    BSS_NAD      = 4'h4,
    BSS_WINDOW   = 4'hC,
    BSS_LOADER   = 4'hD,
    BSS_USER     = 4'hF,
    BSS_DEBUG    = 4'hE,
    BSS_ERR_LOOP = 4'hA
  } bss_state_t;

  typedef enum logic [1:0] {
    BSS_COLD = 2'h0,
    BSS_WARM = 2'h1,
    BSS_HOT  = 2'h2
  } bss_rtype_t;

endpackage : bss_pkg

//--- src/bss_seq.sv
// boot startup sequencer: reset classification, main_watchdog, ram test
// and init, trimming, timeout and node address checks, loader window
// assumes ram, config sector and trim targets answer on the same clock
//
// How it works
// RULE1 - several resets: cold beats warm beats hot
// RULE2 - sleep/stop exit warm; pin, por, wdt, fail cold
// RULE3 - type from reset_cause_register; software clears bits
// RULE4 - watchdog starts long window, stays on for user
// RULE5 - watchdog off before debug mode
// RULE6 - host sync in window freezes the watchdog
// RULE7 - ram self-test by default only after cold
// RULE8 - zero-init after cold, warm; hot only forced
// RULE9 - forced covers whole ram, warm skips 1kB
// RULE10 - linear write then read, alternating patterns
// RULE11 - test failure: record, loop, watchdog resets
// RULE12 - five consecutive watchdog resets force sleep
// RULE13 - init writes zero with matching check bits
// RULE14 - normal ram port blocked during self-test
// RULE15 - trim copied; failing crc uses predefined values
// RULE16 - cold/warm copy user pages 0 and 1
// RULE17 - user page crc failure flags, loads backup
// RULE18 - loader mode error: safe mode, then sleep
// RULE19 - nvm double-bit error: endless loop always
// RULE20 - timeout stored with inverse, compared before use
// RULE21 - invalid timeout passes wait-forever value
// RULE22 - invalid node address passes broadcast
// RULE23 - timeout counts 5 ms steps, max 140
// RULE24 - zero timeout enters user mode at once
// RULE25 - steps run in order, user mode last
`timescale 1ns/100ps
`include "bss_params.svh"

module bss_seq #(
  parameter int          RAM_AW       = 12,
  parameter int          TRIM_PAGES   = 4,
  parameter int          STEP_CYC     = `BSS_STEP_CYC,
  parameter logic [31:0] WDT_LONG_CYC = `BSS_WDT_LONG_CYC,
  parameter logic [31:0] WDT_WIN_CYC  = `BSS_WDT_WIN_CYC,
  parameter logic [31:0] TRIM_DFLT    = 32'h00000000,
  parameter logic [31:0] USER_BACKUP  = 32'h00000000
) (
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_B_I,
  input  wire logic [3:0]        ADDR_I,
  input  wire logic [31:0]       WR_DATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [31:0]       RD_DATA_O,
  input  wire logic [7:0]        RST_EVT_I,
  input  wire logic              DEBUG_REQ_I,
  input  wire logic              USER_LDR_I,
  input  wire logic              WDT_KICK_I,
  input  wire logic              HOST_SYNC_I,
  input  wire logic              LOADER_EXIT_I,
  output logic                   RAM_WE_O,
  output logic                   RAM_RE_O,
  output logic      [RAM_AW-1:0] RAM_ADDR_O,
  output logic      [31:0]       RAM_WDATA_O,
  output logic      [3:0]        RAM_ECC_O,
  input  wire logic [31:0]       RAM_RDATA_I,
  output logic                   RAM_BLOCK_O,
  output logic                   NVM_REQ_O,
  output logic      [7:0]        NVM_ADDR_O,
  input  wire logic              NVM_ACK_I,
  input  wire logic [31:0]       NVM_DATA_I,
  input  wire logic              NVM_CRC_OK_I,
  input  wire logic              NVM_DBE_I,
  output logic                   TRIM_WE_O,
  output logic      [3:0]        TRIM_SEL_O,
  output logic      [31:0]       TRIM_DATA_O,
  output logic      [7:0]        NAC_O,
  output logic      [7:0]        NAD_O,
  output bss_pkg::bss_state_t    STATE_O,
  output logic                   WDT_EN_O,
  output logic                   WDT_FRZ_O,
  output logic                   LOADER_O,
  output logic                   USER_MODE_O,
  output logic                   DEBUG_MODE_O,
  output logic                   SAFE_MODE_O,
  output logic                   HALT_O,
  output logic                   SLEEP_O
);
  import bss_pkg::*;

  if (RAM_AW <= 8 || RAM_AW > 24) begin : g_chk_aw
    $error("RAM_AW must leave room above the excluded low range");
  end
  if (TRIM_PAGES < 1 || TRIM_PAGES > 14) begin : g_chk_tp
    $error("TRIM_PAGES must be 1 to 14");
  end
  if (STEP_CYC < 1 || STEP_CYC >= (1 << 24)) begin : g_chk_step
    $error("STEP_CYC must fit the 24-bit tick counter");
  end

  localparam logic [3:0]        TP_LAST  = 4'(TRIM_PAGES + 1);
  localparam logic [3:0]        TP_NUM   = 4'(TRIM_PAGES);
  localparam logic [23:0]       TICK_END = 24'(STEP_CYC - 1);
  localparam logic [RAM_AW-1:0] LOW_BASE = RAM_AW'(`BSS_LOW_EXCL_WORDS);

  typedef struct packed {
    bss_state_t        st;
    bss_rtype_t        rtype;
    logic [7:0]        cause;
    logic              force_tst;
    logic [2:0]        dbg_s;
    logic [2:0]        ldr_s;
    logic              dbg;
    logic              ldr;
    logic              do_test;
    logic [RAM_AW-1:0] addr;
    logic [1:0]        rd_ph;
    logic [3:0]        idx;
    logic              err_crc;
    logic              err_ram;
    logic              err_dbe;
    logic              safe;
    logic [7:0]        nac;
    logic [7:0]        nad;
    logic [23:0]       tick;
    logic [7:0]        steps;
    logic [31:0]       wdt_cnt;
    logic              wdt_open;
    logic              wdt_en;
    logic              wdt_frz;
    logic [2:0]        wdt_cons;
    logic              sleep;
    logic [31:0]       rdata;
    logic              ram_we;
    logic              ram_re;
    logic [RAM_AW-1:0] ram_addr;
    logic [31:0]       ram_wd;
    logic [3:0]        ram_ecc;
    logic              nvm_req;
    logic [7:0]        nvm_addr;
    logic              trim_we;
    logic [3:0]        trim_sel;
    logic [31:0]       trim_data;
  } bss_regs_t;

  bss_regs_t state_r;
  bss_regs_t state_nxt;

  function automatic logic [3:0] bss_ecc(input logic [31:0] d);
    logic [3:0] e;
    e = 4'h0;
    for (int i = 0; i < 4; i++) begin
      e[i] = ^d[8*i +: 8];
    end
    return e;
  endfunction : bss_ecc

  function automatic logic [31:0] bss_pat(input logic odd);
    return odd ? `BSS_PAT_ODD : `BSS_PAT_EVEN;
  endfunction : bss_pat

  logic [31:0]       wdt_lim;
  logic              wdt_run;
  logic              wdt_to;
  logic              restart;
  logic              nvm_done;
  logic [RAM_AW-1:0] base;
  logic              rec_ok;
  logic [7:0]        rec_val;

  always_comb begin
    wdt_lim  = state_r.wdt_open ? WDT_LONG_CYC : WDT_WIN_CYC;
    wdt_run  = state_r.wdt_en && !state_r.wdt_frz;
    wdt_to   = wdt_run && !WDT_KICK_I && (state_r.wdt_cnt == wdt_lim - 32'h1);
    restart  = (|RST_EVT_I) || wdt_to;
    nvm_done = state_r.nvm_req && NVM_ACK_I;
    // warm reset with forced test leaves the low range to software [RULE9]
    base     = (state_r.rtype == BSS_WARM && state_r.force_tst) ? LOW_BASE : '0;
    rec_ok   = NVM_DATA_I[7:0] == ~NVM_DATA_I[15:8]; // [RULE20]
    rec_val  = NVM_DATA_I[7:0];
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.ram_we  = 1'b0;
    state_nxt.ram_re  = 1'b0;
    state_nxt.trim_we = 1'b0;
    state_nxt.rdata   = 32'h00000000;

    // only the second and third stage decide; the first feeds the second only
    state_nxt.dbg_s = {state_r.dbg_s[1:0], DEBUG_REQ_I};
    state_nxt.ldr_s = {state_r.ldr_s[1:0], USER_LDR_I};
    if (state_r.dbg_s[2] == state_r.dbg_s[1]) begin
      state_nxt.dbg = state_r.dbg_s[1];
    end
    if (state_r.ldr_s[2] == state_r.ldr_s[1]) begin
      state_nxt.ldr = state_r.ldr_s[1];
    end

    // register port; a new event beats a clear in the same cycle [RULE3]
    state_nxt.cause = state_r.cause;
    if (WR_I && ADDR_I == `BSS_ADR_CAUSE) begin
      state_nxt.cause = state_r.cause & ~WR_DATA_I[7:0];
    end
    state_nxt.cause = state_nxt.cause | RST_EVT_I;
    state_nxt.cause[`BSS_CAUSE_WDT] = state_nxt.cause[`BSS_CAUSE_WDT] | wdt_to;
    if (WR_I && ADDR_I == `BSS_ADR_CTRL) begin
      state_nxt.force_tst = WR_DATA_I[`BSS_CTRL_FORCE];
    end
    if (RD_I) begin
      case (ADDR_I)
        `BSS_ADR_CAUSE:  state_nxt.rdata = {24'h000000, state_r.cause};
        `BSS_ADR_CTRL:   state_nxt.rdata = {31'h00000000, state_r.force_tst};
        `BSS_ADR_STATUS: state_nxt.rdata = {18'h00000, state_r.sleep, state_r.safe,
                                            state_r.err_dbe, state_r.err_ram,
                                            state_r.err_crc, state_r.wdt_cons,
                                            state_r.rtype, state_r.st};
        `BSS_ADR_RESULT: state_nxt.rdata = {16'h0000, state_r.nad, state_r.nac};
        default:         state_nxt.rdata = 32'h00000000;
      endcase
    end

    // main_watchdog: a kick while running restarts the normal window
    if (wdt_run) begin
      if (WDT_KICK_I) begin
        state_nxt.wdt_cnt  = 32'h0;
        state_nxt.wdt_open = 1'b0;
      end else begin
        state_nxt.wdt_cnt = state_r.wdt_cnt + 32'h1;
      end
    end

    case (state_r.st)
      BSS_CLASSIFY: begin
        // cold outranks warm outranks hot [RULE1] [RULE2] [RULE3]
        if (|(state_r.cause & `BSS_COLD_MASK)) begin
          state_nxt.rtype = BSS_COLD;
        end else if (|(state_r.cause & `BSS_WARM_MASK)) begin
          state_nxt.rtype = BSS_WARM;
        end else begin
          state_nxt.rtype = BSS_HOT;
        end
        state_nxt.st = BSS_WDT_SET;
      end
      BSS_WDT_SET: begin
        state_nxt.wdt_en   = 1'b1; // long open window on every path [RULE4]
        state_nxt.wdt_frz  = 1'b0;
        state_nxt.wdt_open = 1'b1;
        state_nxt.wdt_cnt  = 32'h0;
        state_nxt.do_test  = state_r.rtype == BSS_COLD || state_r.force_tst; // [RULE7]
        state_nxt.addr     = base;
        state_nxt.rd_ph    = 2'h0;
        state_nxt.idx      = 4'h0;
        state_nxt.err_crc  = 1'b0;
        if (state_r.rtype == BSS_COLD || state_r.force_tst) begin
          state_nxt.st = BSS_TEST_WR; // [RULE25]
        end else if (state_r.rtype == BSS_WARM) begin
          state_nxt.st = BSS_INIT; // [RULE8]
        end else begin
          state_nxt.st = BSS_NAC; // hot skips ram work and trimming [RULE8]
        end
      end
      BSS_TEST_WR: begin
        state_nxt.ram_we   = 1'b1; // [RULE10]
        state_nxt.ram_addr = state_r.addr;
        state_nxt.ram_wd   = bss_pat(state_r.addr[0]);
        state_nxt.ram_ecc  = bss_ecc(bss_pat(state_r.addr[0]));
        state_nxt.addr     = state_r.addr + 1'b1;
        if (&state_r.addr) begin
          state_nxt.addr = base;
          state_nxt.st   = BSS_TEST_RD;
        end
      end
      BSS_TEST_RD: begin
        // issue, wait for the registered strobe, then compare
        state_nxt.rd_ph = state_r.rd_ph + 2'h1;
        if (state_r.rd_ph == 2'h0) begin
          state_nxt.ram_re   = 1'b1;
          state_nxt.ram_addr = state_r.addr;
        end else if (state_r.rd_ph == 2'h2) begin
          state_nxt.rd_ph = 2'h0;
          if (RAM_RDATA_I != bss_pat(state_r.addr[0])) begin
            state_nxt.err_ram = 1'b1; // [RULE11]
            state_nxt.st      = BSS_ERR_LOOP;
          end else if (&state_r.addr) begin
            state_nxt.addr = base;
            state_nxt.st   = BSS_INIT;
          end else begin
            state_nxt.addr = state_r.addr + 1'b1;
          end
        end
      end
      BSS_INIT: begin
        state_nxt.ram_we   = 1'b1;
        state_nxt.ram_addr = state_r.addr;
        state_nxt.ram_wd   = 32'h00000000;
        state_nxt.ram_ecc  = bss_ecc(32'h00000000); // [RULE13]
        state_nxt.addr     = state_r.addr + 1'b1;
        if (&state_r.addr) begin
          state_nxt.st = (state_r.rtype == BSS_HOT) ? BSS_NAC : BSS_TRIM;
        end
      end
      BSS_TRIM: begin
        state_nxt.nvm_req  = !nvm_done;
        state_nxt.nvm_addr = (state_r.idx < TP_NUM) ?
                             `BSS_CS_TRIM_BASE + {4'h0, state_r.idx} :
                             `BSS_CS_USER0 + {4'h0, state_r.idx - TP_NUM};
        if (nvm_done) begin
          if (NVM_DBE_I) begin
            state_nxt.err_dbe = 1'b1; // [RULE19]
            state_nxt.st      = BSS_ERR_LOOP;
          end else begin
            state_nxt.trim_we  = 1'b1; // [RULE15] [RULE16]
            state_nxt.trim_sel = state_r.idx;
            if (NVM_CRC_OK_I) begin
              state_nxt.trim_data = NVM_DATA_I;
            end else if (state_r.idx < TP_NUM) begin
              state_nxt.trim_data = TRIM_DFLT; // [RULE15]
            end else begin
              state_nxt.trim_data = USER_BACKUP; // [RULE17]
              state_nxt.err_crc   = 1'b1;
            end
            state_nxt.idx = state_r.idx + 4'h1;
            if (state_r.idx == TP_LAST) begin
              state_nxt.st = BSS_NAC;
            end
          end
        end
      end
      BSS_NAC: begin
        if (state_r.err_crc) begin
          // startup error: loop, safe mode only under the user loader [RULE18]
          state_nxt.safe = state_r.ldr;
          state_nxt.st   = BSS_ERR_LOOP;
        end else begin
          state_nxt.nvm_req  = !nvm_done;
          state_nxt.nvm_addr = `BSS_CS_NAC;
          if (nvm_done) begin
            state_nxt.st = BSS_NAD;
            if (NVM_DBE_I) begin
              state_nxt.err_dbe = 1'b1; // [RULE19]
              state_nxt.st      = BSS_ERR_LOOP;
            end else if (!rec_ok) begin
              state_nxt.nac = `BSS_NAC_FOREVER; // [RULE21]
            end else if (rec_val != `BSS_NAC_FOREVER &&
                         rec_val > `BSS_NAC_MAX_STEPS) begin
              state_nxt.nac = `BSS_NAC_MAX_STEPS; // [RULE23]
            end else begin
              state_nxt.nac = rec_val;
            end
          end
        end
      end
      BSS_NAD: begin
        state_nxt.nvm_req  = !nvm_done;
        state_nxt.nvm_addr = `BSS_CS_NAD;
        state_nxt.tick     = 24'h0;
        state_nxt.steps    = 8'h00;
        if (nvm_done) begin
          state_nxt.nad = rec_ok ? rec_val : `BSS_NAD_BCAST; // [RULE22]
          if (NVM_DBE_I) begin
            state_nxt.err_dbe = 1'b1; // [RULE19]
            state_nxt.st      = BSS_ERR_LOOP;
          end else if (state_r.dbg) begin
            state_nxt.wdt_en = 1'b0; // [RULE5]
            state_nxt.st     = BSS_DEBUG;
          end else if (state_r.nac == `BSS_NAC_CLOSED) begin
            state_nxt.st = BSS_USER; // [RULE24]
          end else begin
            // wait-forever window runs with the watchdog held
            state_nxt.wdt_frz = state_r.nac == `BSS_NAC_FOREVER;
            state_nxt.st      = BSS_WINDOW;
          end
        end
      end
      BSS_WINDOW: begin
        if (HOST_SYNC_I) begin
          state_nxt.wdt_frz = 1'b1; // [RULE6]
          state_nxt.st      = BSS_LOADER;
        end else if (state_r.nac != `BSS_NAC_FOREVER) begin
          state_nxt.tick = state_r.tick + 24'h1; // [RULE23]
          if (state_r.tick == TICK_END) begin
            state_nxt.tick  = 24'h0;
            state_nxt.steps = state_r.steps + 8'h1;
            if (state_r.steps + 8'h1 == state_r.nac) begin
              state_nxt.st = BSS_USER;
            end
          end
        end
      end
      BSS_LOADER: begin
        if (LOADER_EXIT_I) begin
          state_nxt.wdt_cnt = 32'h0;
          state_nxt.st      = BSS_USER;
        end
      end
      BSS_USER: begin
        // user code cannot turn the watchdog off [RULE4]
        state_nxt.wdt_en   = 1'b1;
        state_nxt.wdt_frz  = 1'b0;
        state_nxt.wdt_cons = 3'h0;
      end
      BSS_DEBUG: begin
        state_nxt.wdt_en = 1'b0; // [RULE5]
      end
      BSS_ERR_LOOP: begin
        // endless loop; the running watchdog ends it [RULE11] [RULE19]
        state_nxt.st = BSS_ERR_LOOP;
      end
      default: begin
        state_nxt.st = BSS_CLASSIFY;
      end
    endcase

    if (restart) begin
      state_nxt.st       = BSS_CLASSIFY;
      state_nxt.nvm_req  = 1'b0;
      state_nxt.safe     = 1'b0;
      state_nxt.err_ram  = 1'b0;
      state_nxt.err_dbe  = 1'b0;
      state_nxt.wdt_en   = 1'b1;
      state_nxt.wdt_frz  = 1'b0;
      state_nxt.wdt_open = 1'b1;
      state_nxt.wdt_cnt  = 32'h0;
      if (wdt_to) begin
        state_nxt.wdt_cons = state_r.wdt_cons + 3'h1;
        if (state_r.wdt_cons + 3'h1 == `BSS_WDT_SLEEP_CNT) begin
          state_nxt.sleep = 1'b1; // [RULE12] [RULE18]
        end
      end
    end
    if (state_r.sleep) begin
      // asleep: nothing runs until a sleep-exit event wakes the device
      state_nxt.st     = BSS_CLASSIFY;
      state_nxt.wdt_en = 1'b0;
      if (RST_EVT_I[`BSS_CAUSE_SLEEPX]) begin
        state_nxt.sleep    = 1'b0;
        state_nxt.wdt_cons = 3'h0;
        state_nxt.wdt_en   = 1'b1;
      end
    end

    if (!RST_B_I) begin
      state_nxt          = '0;
      state_nxt.st       = BSS_CLASSIFY;
      state_nxt.cause    = `BSS_CAUSE_RST;
      state_nxt.wdt_en   = 1'b1;
      state_nxt.wdt_open = 1'b1;
      state_nxt.nac      = `BSS_NAC_RST;
      state_nxt.nad      = `BSS_NAD_RST;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    state_r <= state_nxt;
  end

  assign RD_DATA_O    = state_r.rdata;
  assign RAM_WE_O     = state_r.ram_we;
  assign RAM_RE_O     = state_r.ram_re;
  assign RAM_ADDR_O   = state_r.ram_addr;
  assign RAM_WDATA_O  = state_r.ram_wd;
  assign RAM_ECC_O    = state_r.ram_ecc;
  assign RAM_BLOCK_O  = state_r.st == BSS_TEST_WR || state_r.st == BSS_TEST_RD; // [RULE14]
  assign NVM_REQ_O    = state_r.nvm_req;
  assign NVM_ADDR_O   = state_r.nvm_addr;
  assign TRIM_WE_O    = state_r.trim_we;
  assign TRIM_SEL_O   = state_r.trim_sel;
  assign TRIM_DATA_O  = state_r.trim_data;
  assign NAC_O        = state_r.nac;
  assign NAD_O        = state_r.nad;
  assign STATE_O      = state_r.st;
  assign WDT_EN_O     = state_r.wdt_en;
  assign WDT_FRZ_O    = state_r.wdt_frz;
  assign LOADER_O     = state_r.st == BSS_WINDOW || state_r.st == BSS_LOADER;
  assign USER_MODE_O  = state_r.st == BSS_USER;
  assign DEBUG_MODE_O = state_r.st == BSS_DEBUG;
  assign SAFE_MODE_O  = state_r.safe;
  assign HALT_O       = state_r.st == BSS_ERR_LOOP;
  assign SLEEP_O      = state_r.sleep;

endmodule : bss_seq

//--- sim/bss_seq_checker.sv
// assertions on the boot startup sequencer ports
// assumes bss_seq port names; bound at the foot
`timescale 1ns/100ps
`include "bss_params.svh"
module bss_seq_checker
  import bss_pkg::*;
#(
  parameter int RAM_AW = 12
) (
  input wire logic              REF_CLK_I,
  input wire logic              RST_B_I,
  input wire logic [7:0]        RST_EVT_I,
  input wire logic              RAM_WE_O,
  input wire logic              RAM_BLOCK_O,
  input wire logic [RAM_AW-1:0] RAM_ADDR_O,
  input wire logic [31:0]       RAM_WDATA_O,
  input wire logic [3:0]        RAM_ECC_O,
  input wire logic [7:0]        NAC_O,
  input wire bss_state_t        STATE_O,
  input wire logic              WDT_EN_O,
  input wire logic              WDT_FRZ_O,
  input wire logic              USER_MODE_O,
  input wire logic              DEBUG_MODE_O,
  input wire logic              SLEEP_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  user_wdt_a: assert property (USER_MODE_O |-> WDT_EN_O)
    else $error("watchdog off in user mode");
  debug_wdt_a: assert property (DEBUG_MODE_O |-> !WDT_EN_O)
    else $error("watchdog on in debug mode");
  loader_frz_a: assert property ($rose(STATE_O == BSS_LOADER) |-> ##[0:1] WDT_FRZ_O)
    else $error("watchdog not frozen in loader");
  test_block_a: assert property (RAM_WE_O && RAM_WDATA_O != 32'h0 |-> RAM_BLOCK_O)
    else $error("ram port open during test");
  test_pattern_a: assert property (RAM_WE_O && RAM_BLOCK_O |->
    RAM_WDATA_O == (RAM_ADDR_O[0] ? `BSS_PAT_ODD : `BSS_PAT_EVEN))
    else $error("wrong test pattern");
  init_zero_a: assert property (RAM_WE_O && !RAM_BLOCK_O |-> RAM_ECC_O == 4'h0)
    else $error("init word with bad check bits");
  sleep_hold_a: assert property (SLEEP_O && !RST_EVT_I[4] |=> SLEEP_O)
    else $error("sleep left early");
  window_open_a: assert property (STATE_O == BSS_WINDOW |-> NAC_O != 8'h00)
    else $error("window with zero timeout");
  nac_cap_a: assert property (STATE_O == BSS_WINDOW |-> NAC_O <= 8'h1C || NAC_O == 8'hFF)
    else $error("timeout above cap");
endmodule : bss_seq_checker

bind bss_seq bss_seq_checker #(.RAM_AW(RAM_AW)) u_bss_seq_checker (.*);

//--- sim/bss_seq_tb.sv
// bench for the boot startup sequencer: timeout table, reset types, errors
// assumes a 512-word ram and short watchdog and step counts
`timescale 1ns/100ps
`include "bss_params.svh"
module bss_seq_tb;
  import bss_pkg::*;
  localparam int          AW = 9;
  localparam logic [15:0] CW = 16'(2 << AW);
  localparam logic [15:0] IW = 16'(1 << AW);
  localparam logic [31:0] DFLT = 32'h00000A5A;
  localparam logic [31:0] TRW = 32'h12345678;
  logic REF_CLK_I, RST_B_I, WR_I, RD_I, DEBUG_REQ_I, USER_LDR_I, WDT_KICK_I;
  logic HOST_SYNC_I, LOADER_EXIT_I, NVM_ACK_I, NVM_CRC_OK_I, NVM_DBE_I, bad;
  logic RAM_WE_O, RAM_RE_O, RAM_BLOCK_O, NVM_REQ_O, TRIM_WE_O, WDT_EN_O, WDT_FRZ_O;
  logic LOADER_O, USER_MODE_O, DEBUG_MODE_O, SAFE_MODE_O, HALT_O, SLEEP_O;
  logic [3:0]  ADDR_I, RAM_ECC_O, TRIM_SEL_O;
  logic [AW-1:0] RAM_ADDR_O;
  logic [7:0]  RST_EVT_I, NVM_ADDR_O, NAC_O, NAD_O;
  logic [31:0] WR_DATA_I, RD_DATA_O, RAM_WDATA_O, RAM_RDATA_I, NVM_DATA_I, TRIM_DATA_O;
  logic [31:0] nacw, nadw, rdv, mem [2**AW];
  bss_state_t  STATE_O;
  int          errors = 0, cmp_count = 0, cyc = 0, nwr = 0, w0;
  // nac word, nad word, expected nac, expected nad
  logic [31:0] rows [4][4] = '{'{32'hFC03, 32'hEF10, 32'h03, 32'h10},
    '{32'hFF00, 32'hEF10, 32'h00, 32'h10}, '{32'hBF40, 32'h00FF, 32'h1C, 32'hFF},
    '{32'hFF03, 32'h1010, 32'hFF, 32'hFF}};
  // ram writes, type, reset events
  logic [31:0] evs [10] = '{{CW, 8'h0, 8'h01}, {CW, 8'h0, 8'h02}, {CW, 8'h0, 8'h04},
    {CW, 8'h0, 8'h08}, {IW, 8'h1, 8'h10}, {IW, 8'h1, 8'h20}, {16'h0, 8'h2, 8'h40},
    {16'h0, 8'h2, 8'h80}, {CW, 8'h0, 8'h41}, {IW, 8'h1, 8'h50}};

  bss_seq #(.RAM_AW(AW), .STEP_CYC(20), .WDT_LONG_CYC(32'h00000FA0),
    .WDT_WIN_CYC(32'h000003E8), .TRIM_DFLT(DFLT), .USER_BACKUP(DFLT)) u_bss_seq (.*);

  initial begin
    REF_CLK_I = 1'b0;
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // ram and config sector answer one clock after the request; a bad flag corrupts ram reads
  always @(posedge REF_CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors = errors + 1;
      results();
    end
    if (RAM_WE_O) mem[RAM_ADDR_O] <= RAM_WDATA_O;
    nwr <= nwr + int'(RAM_WE_O);
    RAM_RDATA_I <= bad ? ~mem[RAM_ADDR_O] : mem[RAM_ADDR_O];
    NVM_ACK_I <= NVM_REQ_O & ~NVM_ACK_I;
    NVM_DATA_I <= NVM_ADDR_O == 8'h20 ? nacw : NVM_ADDR_O == 8'h21 ? nadw : TRW;
    if (TRIM_WE_O) check("trim", TRIM_DATA_O, NVM_CRC_OK_I ? TRW : DFLT);
  end

  task automatic do_reset();
    RST_B_I <= 1'b0;
    repeat (6) @(posedge REF_CLK_I);
    RST_B_I <= 1'b1;
    @(posedge REF_CLK_I);
  endtask : do_reset

  task automatic bus_wr(logic [3:0] a, logic [31:0] d);
    ADDR_I <= a;
    WR_DATA_I <= d;
    WR_I <= 1'b1;
    @(posedge REF_CLK_I);
    WR_I <= 1'b0;
    @(posedge REF_CLK_I);
  endtask : bus_wr

  task automatic bus_rd(logic [3:0] a);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge REF_CLK_I);
    RD_I <= 1'b0;
    #1 rdv = RD_DATA_O;
    @(posedge REF_CLK_I);
  endtask : bus_rd

  task automatic pulse(int which);
    {HOST_SYNC_I, LOADER_EXIT_I} <= which[1:0];
    @(posedge REF_CLK_I);
    {HOST_SYNC_I, LOADER_EXIT_I} <= 2'b00;
    repeat (2) @(posedge REF_CLK_I);
  endtask : pulse

  initial begin
    {WR_I, RD_I, DEBUG_REQ_I, USER_LDR_I, WDT_KICK_I, HOST_SYNC_I, LOADER_EXIT_I} = '0;
    {ADDR_I, WR_DATA_I, RST_EVT_I, NVM_DBE_I, bad, nacw, nadw} = '0;
    NVM_CRC_OK_I = 1'b1;
    do_reset();
    bus_rd(`BSS_ADR_CAUSE);
    check("cause", rdv, 32'h1);
    bus_rd(4'h2);
    check("unmapped", rdv, 32'h0);
    foreach (rows[i]) begin
      nacw <= rows[i][0];
      nadw <= rows[i][1];
      do_reset();
      for (int k = 0; k < 3500 && !USER_MODE_O && !LOADER_O; k++) @(posedge REF_CLK_I);
      check("nac", 32'(NAC_O), rows[i][2]);
      check("nad", 32'(NAD_O), rows[i][3]);
      for (int k = 0; k < 700 && !USER_MODE_O; k++) @(posedge REF_CLK_I);
      check("user", 32'(USER_MODE_O), 32'(rows[i][2] != 32'hFF));
    end
    pulse(2);
    check("frozen", 32'({LOADER_O, WDT_FRZ_O}), 32'h3);
    pulse(1);
    check("resume", 32'({USER_MODE_O, WDT_EN_O, WDT_FRZ_O}), 32'h6);
    nacw <= 32'hFF00;
    foreach (evs[i]) begin
      bus_wr(`BSS_ADR_CAUSE, 32'hFF);
      w0 = nwr;
      RST_EVT_I <= evs[i][7:0];
      @(posedge REF_CLK_I);
      RST_EVT_I <= 8'h00;
      repeat (2) @(posedge REF_CLK_I);
      for (int k = 0; k < 3500 && !USER_MODE_O; k++) @(posedge REF_CLK_I);
      check("writes", 32'(nwr - w0), 32'(evs[i][31:16]));
      bus_rd(`BSS_ADR_STATUS);
      check("type", 32'(rdv[5:4]), 32'(evs[i][15:8]));
      bus_rd(`BSS_ADR_CAUSE);
      check("cause", rdv, 32'(evs[i][7:0]));
    end
    DEBUG_REQ_I <= 1'b1;
    do_reset();
    for (int k = 0; k < 3500 && !DEBUG_MODE_O; k++) @(posedge REF_CLK_I);
    check("debug", 32'({DEBUG_MODE_O, WDT_EN_O}), 32'h2);
    {DEBUG_REQ_I, NVM_CRC_OK_I, USER_LDR_I} <= 3'b001;
    do_reset();
    for (int k = 0; k < 3500 && !HALT_O; k++) @(posedge REF_CLK_I);
    bus_rd(`BSS_ADR_STATUS);
    check("crc", 32'({HALT_O, SAFE_MODE_O, rdv[9]}), 32'h7);
    {NVM_CRC_OK_I, NVM_DBE_I} <= 2'b11;
    do_reset();
    for (int k = 0; k < 3500 && !HALT_O; k++) @(posedge REF_CLK_I);
    bus_rd(`BSS_ADR_STATUS);
    check("dbe", 32'({HALT_O, SAFE_MODE_O, rdv[11]}), 32'h5);
    {USER_LDR_I, NVM_DBE_I, bad} <= 3'b001;
    do_reset();
    for (int k = 0; k < 3500 && !HALT_O; k++) @(posedge REF_CLK_I);
    bus_rd(`BSS_ADR_STATUS);
    check("ramerr", 32'({HALT_O, rdv[10]}), 32'h3);
    // five watchdog expiries of the long window; the first four rerun the failing test, the fifth forces sleep
    for (int k = 0; k < 25000 && !SLEEP_O; k++) @(posedge REF_CLK_I);
    bus_rd(`BSS_ADR_STATUS);
    check("sleep", 32'({SLEEP_O, rdv[8:6]}), 32'hD);
    results();
  end
endmodule : bss_seq_tb
